// ===== imc_defs.svh
// Offsets, field positions, reset values, limits and timing counts of the integration and min/max block.
`ifndef IMC_DEFS_SVH
`define IMC_DEFS_SVH

// Register byte offsets on the APB bus.
`define IMC_OFF_PWIN     8'h00
`define IMC_OFF_TWIN     8'h04
`define IMC_OFF_PCYC     8'h08
`define IMC_OFF_TCYC     8'h0c
`define IMC_OFF_MODE     8'h10
`define IMC_OFF_CMD      8'h14
`define IMC_OFF_TOTAL    8'h18
`define IMC_OFF_LAST     8'h1c
`define IMC_OFF_LOW_VAL  8'h20
`define IMC_OFF_LOW_STP  8'h24
`define IMC_OFF_HIGH_VAL 8'h28
`define IMC_OFF_HIGH_STP 8'h2c

// Field positions in the mode and command/status words.
`define IMC_MODE_OVERLAP 0
`define IMC_MODE_FETCH   1
`define IMC_CMD_MEASURE  0
`define IMC_CMD_CLEAR    1
`define IMC_CMD_REINIT   2
`define IMC_STS_BUSY     0
`define IMC_STS_RESULT   1
`define IMC_STS_EXTREME  2
`define IMC_STS_CLR_OK   3

// Reset values and legal ranges.
`define IMC_WIN_RST      19'h0029a
`define IMC_WIN_MAX      32'h00046cd0
`define IMC_PCYC_RST     14'h00ee
`define IMC_PCYC_MAX     32'h00003fff
`define IMC_TCYC_RST     16'h03b8
`define IMC_TCYC_MAX     32'h0000ffff
`define IMC_OVERLAP_RST  1'h1
`define IMC_FETCH_RST    1'h0

// Nominal signal periods in microseconds, used to turn cycle counts into time.
`define IMC_NOM_P_PER_US 12'haee
`define IMC_NOM_T_PER_US 12'h2bc
`define IMC_US_PER_MS    28'h00003e8

// One millisecond in clock cycles at the 40 ns clock period.
`define IMC_MS_NS        1000000
`define IMC_CLK_NS       40
`define IMC_MS_CYCLES    ((`IMC_MS_NS + `IMC_CLK_NS - 1) / `IMC_CLK_NS)

`endif

// ===== imc_pkg.sv
// Types shared by the integration and min/max control block.
`default_nettype none
package imc_pkg;

	// APB request from the bus master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} imc_apb_req_s;

	// APB answer to the bus master.
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} imc_apb_rsp_s;

	// Acquisition sequencer states.
	typedef enum logic [0:0] {
		IMC_IDLE,
		IMC_INTEG
	} imc_phase_e;

	// All state of the block.
	typedef struct packed {
		imc_apb_rsp_s rsp;
		logic [18:0]  pwin;
		logic [18:0]  twin;
		logic [13:0]  pcyc;
		logic [15:0]  tcyc;
		logic         overlap;
		logic         fetch;
		logic         trig_pend;
		logic         clr_ok;
		imc_phase_e   phase;
		logic [14:0]  tick;
		logic [19:0]  ms;
		logic [19:0]  total;
		logic         done;
		logic         result_ok;
		logic [31:0]  last;
		logic         ext_ok;
		logic [31:0]  low_val;
		logic [31:0]  low_stp;
		logic [31:0]  high_val;
		logic [31:0]  high_stp;
	} imc_state_s;

endpackage
`default_nettype wire

// ===== imc_integration_minmax_control.sv
// Integration time settings, acquisition sequencing and min/max tracking behind an APB slave.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "imc_defs.svh"

// Overview of operation
// - Pressure window 1..290000 ms, default 666.
// - Pressure window write copies into temperature window.
// - Temperature window 1..290000 ms, default 666.
// - Temperature window write leaves pressure window alone.
// - Pressure cycle count 1..16383, default 238.
// - Pressure count write sets temperature count fourfold.
// - Temperature count 1..65535, default 952, independent.
// - Cycle counts convert to time via nominal periods.
// - Overlap select: 0 simultaneous, 1 sequential, default 1.
// - Simultaneous mode total time is larger window.
// - Sequential mode total time is window sum.
// - Both signals sampled together; timing mimics sequential.
// - Trigger mode measures only upon a request.
// - Fetch mode acquires continuously, answers with latest.
// - Listed events reload extremes from next measurement.
// - Lowest value query returns tracked minimum.
// - Lowest stamp query returns minimum capture stamp.
// - Extreme clear acknowledges OK and reloads extremes.
module imc_integration_minmax_control #(
	parameter int MS_CYCLES = `IMC_MS_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire imc_pkg::imc_apb_req_s apb_req,
	output var  imc_pkg::imc_apb_rsp_s apb_rsp,
	input  wire logic [31:0]           pressure_value,
	input  wire logic [31:0]           time_stamp,
	input  wire logic                  extremes_reinit,
	output logic                       integrating,
	output logic                       measure_done
);
	import imc_pkg::*;

	imc_state_s s_reg;
	imc_state_s s_next;

	// Matches a bus address against one register offset.
	function automatic logic at_reg(input logic [7:0] addr, input logic [7:0] off);
		at_reg = (addr == off);
	endfunction

	// Turns a cycle count into whole milliseconds, never below one.
	function automatic logic [18:0] cyc_to_ms(input logic [15:0] cyc, input logic [11:0] per_us);
		logic [27:0] prod;
		logic [27:0] quo;
		prod = 28'(cyc) * 28'(per_us);
		quo = prod / `IMC_US_PER_MS;
		cyc_to_ms = (quo == 28'h0) ? 19'h00001 : quo[18:0];
	endfunction

	// Total acquisition time for the present mode and windows.
	function automatic logic [19:0] total_ms(input logic ovl, input logic [18:0] pw, input logic [18:0] tw);
		if (ovl) begin
			total_ms = 20'(pw) + 20'(tw);
		end else begin
			total_ms = (pw > tw) ? 20'(pw) : 20'(tw);
		end
	endfunction

	logic        setup;
	logic        access;
	logic        wr_ok;
	logic [31:0] wd;

	// Bus phase decode; a request is answered in its first access cycle.
	assign setup  = apb_req.psel & ~apb_req.penable & ~s_reg.rsp.pready;
	assign access = apb_req.psel & apb_req.penable & s_reg.rsp.pready;
	assign wd     = apb_req.pwdata;
	assign wr_ok  = access & apb_req.pwrite & ~s_reg.rsp.pslverr;

	// Next-state logic of the whole block.
	always_comb begin
		logic        bad;
		logic [31:0] rd;
		logic [7:0]  a;
		logic        start;
		logic        clr;
		logic        arm;
		bad = 1'b0;
		rd = 32'h0;
		a = apb_req.paddr;
		start = 1'b0;
		clr = 1'b0;
		arm = 1'b0;
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.rsp.pready = setup;
		s_next.rsp.pslverr = 1'b0;
		s_next.rsp.prdata = 32'h0;

		// Setup cycle: read mux, range checks and decode errors.
		if (setup) begin
			if (at_reg(a, `IMC_OFF_PWIN)) begin
				rd = 32'(s_reg.pwin);
				bad = apb_req.pwrite & ((wd == 32'h0) | (wd > `IMC_WIN_MAX));
			end else if (at_reg(a, `IMC_OFF_TWIN)) begin
				rd = 32'(s_reg.twin);
				bad = apb_req.pwrite & ((wd == 32'h0) | (wd > `IMC_WIN_MAX));
			end else if (at_reg(a, `IMC_OFF_PCYC)) begin
				rd = 32'(s_reg.pcyc);
				bad = apb_req.pwrite & ((wd == 32'h0) | (wd > `IMC_PCYC_MAX));
			end else if (at_reg(a, `IMC_OFF_TCYC)) begin
				rd = 32'(s_reg.tcyc);
				bad = apb_req.pwrite & ((wd == 32'h0) | (wd > `IMC_TCYC_MAX));
			end else if (at_reg(a, `IMC_OFF_MODE)) begin
				rd[`IMC_MODE_OVERLAP] = s_reg.overlap;
				rd[`IMC_MODE_FETCH] = s_reg.fetch;
			end else if (at_reg(a, `IMC_OFF_CMD)) begin
				rd[`IMC_STS_BUSY] = (s_reg.phase == IMC_INTEG);
				rd[`IMC_STS_RESULT] = s_reg.result_ok;
				rd[`IMC_STS_EXTREME] = s_reg.ext_ok;
				rd[`IMC_STS_CLR_OK] = s_reg.clr_ok;
			end else if (at_reg(a, `IMC_OFF_TOTAL)) begin
				rd = 32'(total_ms(s_reg.overlap, s_reg.pwin, s_reg.twin));
				bad = apb_req.pwrite;
			end else if (at_reg(a, `IMC_OFF_LAST)) begin
				rd = s_reg.last;
				bad = apb_req.pwrite;
			end else if (at_reg(a, `IMC_OFF_LOW_VAL)) begin
				rd = s_reg.low_val;
				bad = apb_req.pwrite;
			end else if (at_reg(a, `IMC_OFF_LOW_STP)) begin
				rd = s_reg.low_stp;
				bad = apb_req.pwrite;
			end else if (at_reg(a, `IMC_OFF_HIGH_VAL)) begin
				rd = s_reg.high_val;
				bad = apb_req.pwrite;
			end else if (at_reg(a, `IMC_OFF_HIGH_STP)) begin
				rd = s_reg.high_stp;
				bad = apb_req.pwrite;
			end else begin
				bad = 1'b1;
			end
			s_next.rsp.prdata = bad ? 32'h0 : rd;
			s_next.rsp.pslverr = bad;
		end

		// Access cycle: writes take effect at the completing edge.
		if (wr_ok) begin
			if (at_reg(a, `IMC_OFF_PWIN)) begin
				s_next.pwin = wd[18:0];
				s_next.twin = wd[18:0];
			end else if (at_reg(a, `IMC_OFF_TWIN)) begin
				s_next.twin = wd[18:0];
			end else if (at_reg(a, `IMC_OFF_PCYC)) begin
				s_next.pcyc = wd[13:0];
				s_next.tcyc = {wd[13:0], 2'b00};
				s_next.pwin = cyc_to_ms(16'(wd[13:0]), `IMC_NOM_P_PER_US);
				s_next.twin = cyc_to_ms({wd[13:0], 2'b00}, `IMC_NOM_T_PER_US);
			end else if (at_reg(a, `IMC_OFF_TCYC)) begin
				s_next.tcyc = wd[15:0];
				s_next.twin = cyc_to_ms(wd[15:0], `IMC_NOM_T_PER_US);
			end else if (at_reg(a, `IMC_OFF_MODE)) begin
				s_next.overlap = wd[`IMC_MODE_OVERLAP];
				s_next.fetch = wd[`IMC_MODE_FETCH];
			end else if (at_reg(a, `IMC_OFF_CMD)) begin
				if (wd[`IMC_CMD_MEASURE] & ~s_reg.fetch) begin
					s_next.trig_pend = 1'b1;
					arm = 1'b1;
				end
				clr = wd[`IMC_CMD_CLEAR] | wd[`IMC_CMD_REINIT];
				if (wd[`IMC_CMD_CLEAR]) begin
					s_next.clr_ok = 1'b1;
				end
			end
		end

		// Reading status consumes the clear acknowledge.
		if (access & ~apb_req.pwrite & at_reg(a, `IMC_OFF_CMD)) begin
			s_next.clr_ok = 1'b0;
		end

		if (clr | extremes_reinit) begin
			s_next.ext_ok = 1'b0;
		end

		// Acquisition sequencer counting whole milliseconds.
		unique case (s_reg.phase)
			IMC_IDLE: begin
				// start on request or always in fetch
				start = s_reg.fetch | s_reg.trig_pend;
			end
			IMC_INTEG: begin
				if (s_reg.tick == 15'(MS_CYCLES - 1)) begin
					s_next.tick = 15'h0;
					s_next.ms = s_reg.ms + 20'h1;
					if (s_reg.ms + 20'h1 >= s_reg.total) begin
						s_next.done = 1'b1;
						s_next.phase = IMC_IDLE;
					end
				end else begin
					s_next.tick = s_reg.tick + 15'h1;
				end
			end
		endcase
		if (start) begin
			s_next.phase = IMC_INTEG;
			// A request that arrives as the pending one starts stays pending.
			s_next.trig_pend = arm;
			s_next.tick = 15'h0;
			s_next.ms = 20'h0;
			// one concurrent sample, result after total time
			s_next.total = total_ms(s_reg.overlap, s_reg.pwin, s_reg.twin);
		end

		// Result capture and extreme tracking; a capture beats a clear.
		if (s_next.done) begin
			s_next.last = pressure_value;
			s_next.result_ok = 1'b1;
			s_next.ext_ok = 1'b1;
			if (~s_reg.ext_ok | clr | extremes_reinit) begin
				s_next.low_val = pressure_value;
				s_next.low_stp = time_stamp;
				s_next.high_val = pressure_value;
				s_next.high_stp = time_stamp;
			end else begin
				if ($signed(pressure_value) < $signed(s_reg.low_val)) begin
					s_next.low_val = pressure_value;
					s_next.low_stp = time_stamp;
				end
				if ($signed(pressure_value) > $signed(s_reg.high_val)) begin
					s_next.high_val = pressure_value;
					s_next.high_stp = time_stamp;
				end
			end
		end
	end

	// State register with documented defaults at reset.
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.pwin <= `IMC_WIN_RST;
			s_reg.twin <= `IMC_WIN_RST;
			s_reg.pcyc <= `IMC_PCYC_RST;
			s_reg.tcyc <= `IMC_TCYC_RST;
			s_reg.overlap <= `IMC_OVERLAP_RST;
			s_reg.fetch <= `IMC_FETCH_RST;
			s_reg.phase <= IMC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register.
	assign apb_rsp      = s_reg.rsp;
	assign integrating  = (s_reg.phase == IMC_INTEG);
	assign measure_done = s_reg.done;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	logic wr_pwin;
	logic wr_twin;
	logic wr_pcyc;
	logic wr_tcyc;
	logic wr_clear;
	logic wr_mode;
	logic wr_reinit;

	// Completed legal writes seen by the checks below.
	assign wr_pwin  = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_PWIN);
	assign wr_twin  = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_TWIN);
	assign wr_pcyc  = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_PCYC);
	assign wr_tcyc  = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_TCYC);
	assign wr_clear = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_CMD) & apb_req.pwdata[`IMC_CMD_CLEAR];
	assign wr_mode  = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_MODE);
	assign wr_reinit = wr_ok & at_reg(apb_req.paddr, `IMC_OFF_CMD) & apb_req.pwdata[`IMC_CMD_REINIT];

	// Window values stay inside their range.
	window_range_a: assert property ((s_reg.pwin != 19'h0) && (32'(s_reg.pwin) <= `IMC_WIN_MAX))
		else $error("Pressure window out of range.");
	twin_range_a: assert property ((s_reg.twin != 19'h0) && (32'(s_reg.twin) <= `IMC_WIN_MAX))
		else $error("Temperature window out of range.");
	// Pressure window write lands in both windows.
	pwin_copy_a: assert property (wr_pwin |=> (s_reg.twin == $past(apb_req.pwdata[18:0])) && (s_reg.pwin == s_reg.twin))
		else $error("Temperature window did not follow pressure window.");
	// Temperature window write keeps pressure window.
	twin_alone_a: assert property (wr_twin |=> $stable(s_reg.pwin))
		else $error("Pressure window changed on temperature write.");
	// Pressure count write gives a fourfold temperature count.
	tcyc_four_a: assert property (wr_pcyc |=> s_reg.tcyc == {$past(apb_req.pwdata[13:0]), 2'b00})
		else $error("Temperature count is not four times pressure count.");
	// Temperature count write keeps pressure count.
	pcyc_alone_a: assert property (wr_tcyc |=> $stable(s_reg.pcyc))
		else $error("Pressure count changed on temperature write.");
	// Total time follows the overlap selector when a measurement starts.
	total_mode_a: assert property ((s_reg.phase == IMC_IDLE) && (s_reg.fetch || s_reg.trig_pend)
		|=> s_reg.total == total_ms($past(s_reg.overlap), $past(s_reg.pwin), $past(s_reg.twin)))
		else $error("Total acquisition time wrong for the mode.");
	// Trigger mode stays idle without a request.
	trigger_wait_a: assert property ((s_reg.phase == IMC_IDLE) && !s_reg.fetch && !s_reg.trig_pend
		|=> s_reg.phase == IMC_IDLE)
		else $error("Measurement started without a request.");
	// Clear is acknowledged and drops the extremes.
	clear_ack_a: assert property (wr_clear && !s_next.done |=> s_reg.clr_ok && !s_reg.ext_ok)
		else $error("Extreme clear not acknowledged.");
	// A finished measurement lies between the tracked extremes.
	extreme_hold_a: assert property (measure_done |-> s_reg.ext_ok
		&& ($signed(s_reg.low_val) <= $signed(s_reg.last))
		&& ($signed(s_reg.high_val) >= $signed(s_reg.last)))
		else $error("Extremes do not bracket the last result.");

	// Mode write lands in both selector bits.
	mode_write_a: assert property (
		wr_mode |=> (s_reg.overlap == $past(apb_req.pwdata[`IMC_MODE_OVERLAP]))
		&& (s_reg.fetch == $past(apb_req.pwdata[`IMC_MODE_FETCH])))
		else $error("Mode selectors did not take the written value.");
	// Fetch mode restarts as soon as the sequencer is idle.
	fetch_restart_a: assert property ((s_reg.phase == IMC_IDLE) && s_reg.fetch |=> s_reg.phase == IMC_INTEG)
		else $error("Fetch mode did not restart acquisition.");
	// A request made while running is kept for later.
	pend_hold_a: assert property (s_reg.trig_pend && (s_reg.phase == IMC_INTEG) |=> s_reg.trig_pend)
		else $error("Pending measurement request was lost.");
	// A measurement ends exactly when the latched total is reached.
	done_total_a: assert property (measure_done |-> s_reg.ms == s_reg.total)
		else $error("Measurement length differs from total time.");
	// Reload events drop the extremes unless a capture coincides.
	reinit_drop_a: assert property ((extremes_reinit || wr_reinit) && !s_next.done |=> !s_reg.ext_ok)
		else $error("Extremes still valid after a reload event.");
	// Lowest queries answer with the tracked minimum and its stamp.
	low_value_a: assert property (
		setup && !apb_req.pwrite && at_reg(apb_req.paddr, `IMC_OFF_LOW_VAL)
		|=> apb_rsp.prdata == $past(s_reg.low_val))
		else $error("Lowest value query answered wrongly.");
	low_stamp_a: assert property (
		setup && !apb_req.pwrite && at_reg(apb_req.paddr, `IMC_OFF_LOW_STP)
		|=> apb_rsp.prdata == $past(s_reg.low_stp))
		else $error("Lowest stamp query answered wrongly.");
	// Highest queries answer with the tracked maximum and its stamp.
	high_value_a: assert property (
		setup && !apb_req.pwrite && at_reg(apb_req.paddr, `IMC_OFF_HIGH_VAL)
		|=> apb_rsp.prdata == $past(s_reg.high_val))
		else $error("Highest value query answered wrongly.");
	high_stamp_a: assert property (
		setup && !apb_req.pwrite && at_reg(apb_req.paddr, `IMC_OFF_HIGH_STP)
		|=> apb_rsp.prdata == $past(s_reg.high_stp))
		else $error("Highest stamp query answered wrongly.");

	// Main scenarios.
	trigger_done_c: cover property (!s_reg.fetch && measure_done);
	fetch_done_c: cover property (s_reg.fetch && measure_done);
	clear_then_done_c: cover property (wr_clear ##[1:300] measure_done);
	pcyc_write_c: cover property (wr_pcyc);
	reinit_c: cover property (wr_reinit);

endmodule // imc_integration_minmax_control
`default_nettype wire

// ===== imc_host_model.sv
// Host-side APB master model that issues register transfers to the block.
`timescale 1ns/1ns
`default_nettype none
module imc_host_model (
	input  wire logic                  mclk,
	output var  imc_pkg::imc_apb_req_s apb_req,
	input  wire imc_pkg::imc_apb_rsp_s apb_rsp
);
	import imc_pkg::*;

	// The bus is idle from time zero.
	initial begin
		apb_req = '0;
	end

	// One transfer: setup, access held until pready is sampled high, then release.
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge mclk);
		apb_req.psel    <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite  <= wr;
		apb_req.paddr   <= addr;
		apb_req.pwdata  <= wdata;
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		// Waits for the answer however long it takes; the bench watchdog ends a hang.
		do begin
			@(posedge mclk);
		end while (apb_rsp.pready !== 1'b1);
		rdata = apb_rsp.prdata;
		err   = apb_rsp.pslverr;
		// Released lines show the inverse so stale values cannot pass.
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
		apb_req.paddr   <= ~addr;
		apb_req.pwdata  <= ~wdata;
	endtask
endmodule // imc_host_model
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench of the integration and min/max control block.
`timescale 1ns/1ns
`default_nettype none
`include "imc_defs.svh"
module testbench;
	import imc_pkg::*;
	localparam int MS = 4;
	logic         mclk;
	logic         reset;
	imc_apb_req_s apb_req;
	imc_apb_rsp_s apb_rsp;
	logic [31:0]  pressure_value;
	logic [31:0]  time_stamp;
	logic         extremes_reinit;
	logic         integrating;
	logic         measure_done;
	logic [31:0]  rd, pw, tw, pc, lo_v, lo_s, hi_v, hi_s;
	logic         err, ext_ok;
	int           fails, n_checks, seed, cyc, hits, t;

	imc_integration_minmax_control #(.MS_CYCLES(MS)) uut (.mclk(mclk), .reset(reset), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .pressure_value(pressure_value), .time_stamp(time_stamp),
		.extremes_reinit(extremes_reinit), .integrating(integrating), .measure_done(measure_done));
	imc_host_model host (.mclk(mclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

	// Free-running 25 MHz clock.
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// Counts one word comparison and prints it on a mismatch.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bus helpers built on the host model.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd, err);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rd, err);
		chk(what, exp, rd);
	endtask
	task automatic errchk(input string what, input logic exp);
		chk(what, {31'h0, exp}, {31'h0, err});
	endtask
	task automatic tdone(input string name);
		$display("test %s done", name);
	endtask

	// Cycle count to milliseconds through a nominal period, never below one.
	function automatic logic [31:0] ms_of(input logic [31:0] c, input logic [31:0] per);
		logic [31:0] m;
		m = c * per / 32'h3e8;
		return (m == 32'h0) ? 32'h1 : m;
	endfunction
	function automatic logic [31:0] tot(input logic ov, input logic [31:0] p, input logic [31:0] q);
		return ov ? p + q : ((p > q) ? p : q);
	endfunction

	// One measurement with held inputs; updates and checks the extreme model.
	task automatic measure(input logic [31:0] p, input logic [31:0] s, input logic go);
		int n;
		pressure_value <= p;
		time_stamp     <= s;
		if (go) wr(`IMC_OFF_CMD, 32'h1);
		cyc = 0;
		n = 0;
		while (measure_done !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
			if (integrating === 1'b1) cyc++;
		end
		chk("done seen", 32'h1, {31'h0, n < 3000});
		if (!ext_ok || $signed(p) < $signed(lo_v)) begin
			lo_v = p;
			lo_s = s;
		end
		if (!ext_ok || $signed(p) > $signed(hi_v)) begin
			hi_v = p;
			hi_s = s;
		end
		ext_ok = 1'b1;
		rdchk("last", `IMC_OFF_LAST, p);
		rdchk("low value", `IMC_OFF_LOW_VAL, lo_v);
		rdchk("low stamp", `IMC_OFF_LOW_STP, lo_s);
		rdchk("high value", `IMC_OFF_HIGH_VAL, hi_v);
		rdchk("high stamp", `IMC_OFF_HIGH_STP, hi_s);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog sized well above the expected run length.
	initial begin
		repeat (30000) @(posedge mclk);
		fails++;
		$display("watchdog expired");
		summarize();
	end

	// Main sequence.
	initial begin
		seed = 45;
		fails = 0;
		n_checks = 0;
		ext_ok = 1'b0;
		{lo_v, lo_s, hi_v, hi_s} = '0;
		reset = 1'b1;
		pressure_value = 32'h0;
		time_stamp = 32'h0;
		extremes_reinit = 1'b0;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		rdchk("pwin reset", `IMC_OFF_PWIN, 32'h29a);
		rdchk("twin reset", `IMC_OFF_TWIN, 32'h29a);
		rdchk("pcyc reset", `IMC_OFF_PCYC, 32'hee);
		rdchk("tcyc reset", `IMC_OFF_TCYC, 32'h3b8);
		rdchk("mode reset", `IMC_OFF_MODE, 32'h1);
		tdone("defaults");
		repeat (4) begin
			pw = 32'h1 + ($unsigned($random(seed)) % 32'h46cd0);
			tw = 32'h1 + ($unsigned($random(seed)) % 32'h46cd0);
			wr(`IMC_OFF_PWIN, pw);
			rdchk("twin copy", `IMC_OFF_TWIN, pw);
			wr(`IMC_OFF_TWIN, tw);
			rdchk("pwin kept", `IMC_OFF_PWIN, pw);
		end
		wr(`IMC_OFF_PWIN, 32'h46cd0);
		errchk("pwin max accepted", 1'b0);
		wr(`IMC_OFF_PWIN, 32'h46cd1);
		errchk("pwin over refused", 1'b1);
		wr(`IMC_OFF_TWIN, 32'h0);
		errchk("twin zero refused", 1'b1);
		rdchk("pwin after refusal", `IMC_OFF_PWIN, 32'h46cd0);
		rdchk("twin after refusal", `IMC_OFF_TWIN, 32'h46cd0);
		tdone("windows");
		repeat (4) begin
			pc = 32'h1 + ($unsigned($random(seed)) % 32'h3fff);
			wr(`IMC_OFF_PCYC, pc);
			rdchk("tcyc fourfold", `IMC_OFF_TCYC, pc * 4);
			rdchk("pwin from count", `IMC_OFF_PWIN, ms_of(pc, `IMC_NOM_P_PER_US));
			rdchk("twin from count", `IMC_OFF_TWIN, ms_of(pc * 4, `IMC_NOM_T_PER_US));
		end
		wr(`IMC_OFF_TCYC, 32'hffff);
		rdchk("pcyc kept", `IMC_OFF_PCYC, pc);
		rdchk("twin from tcyc", `IMC_OFF_TWIN, ms_of(32'hffff, `IMC_NOM_T_PER_US));
		wr(`IMC_OFF_PCYC, 32'h4000);
		errchk("pcyc over refused", 1'b1);
		wr(`IMC_OFF_TCYC, 32'h10000);
		errchk("tcyc over refused", 1'b1);
		wr(`IMC_OFF_PCYC, pc);
		tdone("cycle counts");
		for (int ov = 1; ov >= 0; ov--) begin
			wr(`IMC_OFF_MODE, {31'h0, ov[0]});
			wr(`IMC_OFF_PWIN, 32'h3);
			wr(`IMC_OFF_TWIN, 32'h2);
			t = int'(tot(ov[0], 32'h3, 32'h2));
			measure($random(seed), $random(seed), 1'b1);
			chk("integration cycles", 32'h1, {31'h0, cyc >= t * MS - 1 && cyc <= t * MS + 2});
			rdchk("total time", `IMC_OFF_TOTAL, tot(ov[0], 32'h3, 32'h2));
		end
		tdone("overlap");
		hits = 0;
		repeat (40) begin
			@(posedge mclk);
			if (integrating !== 1'b0) hits++;
		end
		chk("no unrequested run", 32'h0, hits);
		measure(32'h80000000, 32'h11, 1'b1);
		measure(32'h7fffffff, 32'h22, 1'b1);
		repeat (6) measure($random(seed), $random(seed), 1'b1);
		tdone("extremes");
		wr(`IMC_OFF_CMD, 32'h2);
		rdchk("clear ok status", `IMC_OFF_CMD, 32'ha);
		rdchk("clear ok read once", `IMC_OFF_CMD, 32'h2);
		ext_ok = 1'b0;
		measure($random(seed), 32'h77, 1'b1);
		extremes_reinit <= 1'b1;
		@(posedge mclk);
		extremes_reinit <= 1'b0;
		ext_ok = 1'b0;
		measure($random(seed), 32'h88, 1'b1);
		wr(`IMC_OFF_CMD, 32'h4);
		rdchk("reinit status", `IMC_OFF_CMD, 32'h2);
		ext_ok = 1'b0;
		measure($random(seed), 32'h99, 1'b1);
		tdone("reload");
		wr(`IMC_OFF_MODE, 32'h3);
		measure($random(seed), $random(seed), 1'b0);
		measure($random(seed), $random(seed), 1'b0);
		wr(`IMC_OFF_MODE, 32'h1);
		tdone("fetch");
		host.xfer(1'b0, 8'h30, 32'h0, rd, err);
		errchk("unmapped refused", 1'b1);
		wr(`IMC_OFF_TOTAL, 32'h1);
		errchk("read-only refused", 1'b1);
		tdone("refusals");
		reset <= 1'b1;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		rdchk("pwin after reset", `IMC_OFF_PWIN, 32'h29a);
		rdchk("status after reset", `IMC_OFF_CMD, 32'h0);
		wr(`IMC_OFF_PWIN, 32'h3);
		ext_ok = 1'b0;
		measure($random(seed), 32'haa, 1'b1);
		tdone("power cycle");
		summarize();
	end
endmodule // testbench
`default_nettype wire
